/* File: hdl/rswl_core.sv */
// Sleep timer, oscillator calibration, tuning with battery check, demodulation and data routing.
// Assumes all inputs are synchronous to clk_sys and that arst_n is the power-on reset.
`timescale 1ns/100ps
`default_nettype none

module rswl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Functional notes
// RL1 - Sleep timer runs on oscillator ticks, wakes chip
// RL2 - Sleep duration programmable over full tick range
// RL3 - Calibrate oscillator at power-up, then periodically
// RL4 - Exactly one battery measurement per tuning
// RL5 - Tune when leaving sleep/standby for ready/receive
// RL6 - Latest battery result held readable
// RL7 - Direct mode routes demodulated bit to pin
// RL8 - Packet mode packs bits into receive FIFO
// RL9 - Host configures, commands states, reads FIFO
// RL10 - Power-on reset clears whole block; the FIFO data memory is not reset and the trim loads TRIM_RESET
// RL11 - Host reinitialises everything after power-on reset
// RL12 - Signal strength taken as 8-bit code
// RL13 - FSK demodulation from 1-bit I and Q
// RL14 - Count ticks, pulse wake, restart each sleep
module rswl_core
	import rswl_pkg::*;
#(
	parameter int CAL_PERIOD = CAL_PERIOD_TICKS
) (
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	input  wire rswl_cfg_t         cfg,
	input  wire logic              cmd_valid,
	input  wire rswl_cmd_t         cmd,
	input  wire logic              lpo_tick,
	input  wire logic              battery_meas_done,
	input  wire logic [7:0]        battery_code,
	input  wire logic [7:0]        signal_strength_converter,
	input  wire logic              demod_i,
	input  wire logic              demod_q,
	input  wire logic              bit_strobe,
	input  wire logic              overflow_clear,
	input  wire logic              fifo_rd_ready,
	output logic                   fifo_rd_valid,
	output logic      [BYTE_W-1:0] fifo_rd_data,
	output logic                   battery_meas_req,
	output logic                   synth_tune_req,
	output logic                   wake_pulse,
	output logic      [GPIO_N-1:0] gpio_out,
	output rswl_status_t           status
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	rswl_state_t         state;
	rswl_state_t         next_state;
	rswl_state_t         tune_target;
	logic [TUNE_W-1:0]   tune_cnt;
	logic                meas_pending;
	logic [SLEEP_W-1:0]  sleep_cnt;
	logic [SLEEP_W-1:0]  sleep_limit;
	logic                sleep_hit;
	logic [CALCNT_W-1:0] cal_cycles;
	logic [CALPER_W-1:0] cal_wait;
	logic                cal_active;
	logic                cal_done;
	logic [TRIM_W-1:0]   lpo_trim;
	logic [7:0]          battery_level_result;
	logic [7:0]          rssi_code;
	logic [1:0]          quad_prev;
	logic [1:0]          quad_now;
	logic                fsk_bit;
	logic                demod_bit;
	logic [BYTE_W-1:0]   shift;
	logic [2:0]          bit_idx;
	logic                hold_valid;
	logic [BYTE_W-1:0]   hold_data;
	logic                hold_ready;
	logic                fifo_overflow;
	logic                enter_tune;

	// ------------------------------------------------------------------
	// Main state machine
	// ------------------------------------------------------------------
	// Commands arriving while tuning are ignored so that a tune always completes
	// with its single battery measurement.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_SLEEP, ST_STANDBY: begin
				if (cmd_valid && (cmd == CMD_SYNTH || cmd == CMD_RX)) begin
					next_state = ST_TUNE; // RL5
				end else if (cmd_valid && cmd == CMD_STANDBY) begin
					next_state = ST_STANDBY;
				end else if (cmd_valid && cmd == CMD_SLEEP) begin
					next_state = ST_SLEEP;
				end else if (state == ST_SLEEP && sleep_hit) begin
					next_state = cfg.duty_cycle_en ? ST_TUNE : ST_STANDBY; // RL1
				end
			end
			ST_TUNE: begin
				if (tune_cnt == '0 && !meas_pending) begin
					next_state = tune_target;
				end
			end
			ST_SYNTH, ST_RX: begin
				if (cmd_valid) begin
					unique case (cmd)
						CMD_SLEEP:   next_state = ST_SLEEP;
						CMD_STANDBY: next_state = ST_STANDBY;
						CMD_SYNTH:   next_state = ST_SYNTH;
						CMD_RX:      next_state = ST_RX;
					endcase
				end
			end
			default: next_state = ST_SLEEP;
		endcase
	end

	assign enter_tune = (next_state == ST_TUNE) && (state != ST_TUNE);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_SLEEP; // RL10
		end else begin
			state <= next_state; // RL9
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tune_target <= ST_RX;
		end else if (enter_tune) begin
			tune_target <= (cmd_valid && cmd == CMD_SYNTH) ? ST_SYNTH : ST_RX;
		end
	end

	// ------------------------------------------------------------------
	// Tuning and battery measurement
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tune_cnt         <= '0;
			synth_tune_req   <= 1'b0;
			battery_meas_req <= 1'b0;
			meas_pending     <= 1'b0;
		end else begin
			synth_tune_req   <= enter_tune; // RL5
			battery_meas_req <= enter_tune; // RL4
			if (enter_tune) begin
				tune_cnt     <= TUNE_W'(TUNE_CYCLES - 1);
				meas_pending <= 1'b1;
			end else begin
				if (tune_cnt != '0) begin
					tune_cnt <= tune_cnt - 1'b1;
				end
				if (battery_meas_done) begin
					meas_pending <= 1'b0;
				end
			end
		end
	end

	// Only the answer to the request of this tune is kept.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			battery_level_result <= '0;
		end else if (meas_pending && battery_meas_done) begin
			battery_level_result <= battery_code; // RL6
		end
	end

	// ------------------------------------------------------------------
	// Sleep timer
	// ------------------------------------------------------------------
	assign sleep_limit = (cfg.sleep_ticks == '0) ? SLEEP_W'(SLEEP_MIN_TICKS) : cfg.sleep_ticks;
	assign sleep_hit   = (state == ST_SLEEP) && cfg.sleep_timer_en && lpo_tick
		&& (sleep_cnt + 1'b1 >= sleep_limit); // RL2

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sleep_cnt  <= '0;
			wake_pulse <= 1'b0;
		end else begin
			wake_pulse <= sleep_hit; // RL14
			if (state != ST_SLEEP || sleep_hit) begin
				sleep_cnt <= '0; // RL14
			end else if (cfg.sleep_timer_en && lpo_tick) begin
				sleep_cnt <= sleep_cnt + 1'b1; // RL1
			end
		end
	end

	// ------------------------------------------------------------------
	// Oscillator calibration
	// ------------------------------------------------------------------
	// One oscillator period is measured in system cycles and the trim is nudged
	// by one step per measurement; a fast oscillator gives too few cycles.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cal_active <= 1'b1;
			cal_done   <= 1'b0;
			cal_cycles <= '0;
			cal_wait   <= '0;
			lpo_trim   <= TRIM_RESET;
		end else if (cal_active) begin
			// A zero count means no tick has opened the measurement yet, so the
			// partial period after reset or resume never moves the trim.
			if (!lpo_tick) begin
				if (cal_cycles != '0 && cal_cycles != '1) begin
					cal_cycles <= cal_cycles + 1'b1;
				end
			end else begin
				cal_cycles <= CALCNT_W'(1);
				if (cal_cycles != '0) begin
					if (cal_cycles < CALCNT_W'(LPO_NOM_CYCLES - LPO_TOL_CYCLES)) begin
						lpo_trim <= (lpo_trim == '0) ? lpo_trim : lpo_trim - 1'b1; // RL3
					end else if (cal_cycles > CALCNT_W'(LPO_NOM_CYCLES + LPO_TOL_CYCLES)) begin
						lpo_trim <= (lpo_trim == '1) ? lpo_trim : lpo_trim + 1'b1; // RL3
					end else begin
						cal_active <= 1'b0;
						cal_done   <= 1'b1;
						cal_wait   <= CALPER_W'(CAL_PERIOD - 1);
					end
				end
			end
		end else if (lpo_tick) begin
			if (cal_wait == '0) begin
				cal_active <= 1'b1; // RL3
				cal_cycles <= '0;
			end else begin
				cal_wait <= cal_wait - 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Demodulation
	// ------------------------------------------------------------------
	// I/Q pair mapped to a quadrant in rotation order; the sign of each step
	// gives the frequency offset and so the FSK bit.
	assign quad_now = {demod_i, demod_i ^ demod_q};

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			quad_prev <= '0;
			fsk_bit   <= 1'b0;
			rssi_code <= '0;
		end else begin
			quad_prev <= quad_now; // RL13
			if (quad_now == quad_prev + 2'h1) begin
				fsk_bit <= 1'b1; // RL13
			end else if (quad_now == quad_prev - 2'h1) begin
				fsk_bit <= 1'b0; // RL13
			end
			rssi_code <= signal_strength_converter; // RL12
		end
	end

	assign demod_bit = cfg.ook_mode ? (rssi_code > cfg.ook_threshold) : fsk_bit; // RL12

	// ------------------------------------------------------------------
	// Direct output routing
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gpio_out <= '0;
		end else begin
			gpio_out <= '0;
			if (!cfg.packet_mode && state == ST_RX && cfg.gpio_sel != GPIO_SEL_NONE) begin
				gpio_out[cfg.gpio_sel] <= demod_bit; // RL7
			end
		end
	end

	// ------------------------------------------------------------------
	// Packet path
	// ------------------------------------------------------------------
	// A finished byte waits in the hold stage while the FIFO is full; a further
	// byte arriving then is lost and flagged, the clear never hides it.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shift         <= '0;
			bit_idx       <= '0;
			hold_valid    <= 1'b0;
			hold_data     <= '0;
			fifo_overflow <= 1'b0;
		end else begin
			if (hold_valid && hold_ready) begin
				hold_valid <= 1'b0;
			end
			if (state != ST_RX || !cfg.packet_mode) begin
				bit_idx <= '0;
			end else if (bit_strobe) begin
				shift   <= {shift[BYTE_W-2:0], demod_bit}; // RL8
				bit_idx <= bit_idx + 1'b1;
				if (bit_idx == BIT_LAST) begin
					if (hold_valid && !hold_ready) begin
						fifo_overflow <= 1'b1;
					end else begin
						hold_valid <= 1'b1; // RL8
						hold_data  <= {shift[BYTE_W-2:0], demod_bit};
					end
				end
			end
			if (overflow_clear && !(bit_strobe && bit_idx == BIT_LAST && hold_valid
				&& !hold_ready && state == ST_RX && cfg.packet_mode)) begin
				fifo_overflow <= 1'b0;
			end
		end
	end

	rswl_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (hold_valid),
		.in_ready  (hold_ready),
		.in_data   (hold_data),
		.out_valid (fifo_rd_valid),
		.out_ready (fifo_rd_ready), // RL9
		.out_data  (fifo_rd_data)
	);

	// ------------------------------------------------------------------
	// Status
	// ------------------------------------------------------------------
	assign status.state                = state;
	assign status.lpo_cal_done         = cal_done;
	assign status.lpo_trim             = lpo_trim;
	assign status.battery_level_result = battery_level_result; // RL6
	assign status.rssi_code            = rssi_code;
	assign status.fifo_overflow        = fifo_overflow;

endmodule

`default_nettype wire

/* File: common/rswl_pkg.sv */
// Shared constants and types for the receiver sleep, wake, battery check and data routing block.
// Assumes a 25 MHz system clock and a low power oscillator tick delivered as a one-cycle pulse.
package rswl_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 40;
	localparam int CLK_FREQ_HZ     = 25000000;
	localparam int LPO_FREQ_HZ     = 32000;
	localparam int TUNE_TIME_NS    = 150000;
	localparam int TUNE_CYCLES     = (TUNE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LPO_NOM_CYCLES  = CLK_FREQ_HZ / LPO_FREQ_HZ;
	localparam int LPO_TOL_PERCENT = 1;
	localparam int LPO_TOL_CYCLES  = LPO_NOM_CYCLES * LPO_TOL_PERCENT / 100;
	localparam int CAL_PERIOD_TICKS = 32768;
	localparam int SLEEP_MIN_TICKS = 1;
	localparam int SLEEP_MAX_TICKS = 1341521920;

	// ------------------------------------------------------------------
	// Widths, reset values, field positions
	// ------------------------------------------------------------------
	localparam int SLEEP_W      = 31;
	localparam int TUNE_W       = 12;
	localparam int CALCNT_W     = 11;
	localparam int CALPER_W     = 16;
	localparam int TRIM_W       = 8;
	localparam int BYTE_W       = 8;
	localparam int FIFO_DEPTH   = 4;
	localparam int GPIO_N       = 3;
	localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
	localparam logic [1:0] GPIO_SEL_NONE = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_SLEEP   = 2'h0,
		CMD_STANDBY = 2'h1,
		CMD_SYNTH   = 2'h2,
		CMD_RX      = 2'h3
	} rswl_cmd_t;

	typedef enum logic [4:0] {
		ST_SLEEP   = 5'h01,
		ST_STANDBY = 5'h02,
		ST_TUNE    = 5'h04,
		ST_SYNTH   = 5'h08,
		ST_RX      = 5'h10
	} rswl_state_t;

	typedef struct packed {
		logic               sleep_timer_en;
		logic               duty_cycle_en;
		logic [SLEEP_W-1:0] sleep_ticks;
		logic               packet_mode;
		logic               ook_mode;
		logic [7:0]         ook_threshold;
		logic [1:0]         gpio_sel;
	} rswl_cfg_t;

	typedef struct packed {
		rswl_state_t       state;
		logic              lpo_cal_done;
		logic [TRIM_W-1:0] lpo_trim;
		logic [7:0]        battery_level_result;
		logic [7:0]        rssi_code;
		logic              fifo_overflow;
	} rswl_status_t;

endpackage

/* File: dv/rswl_monitor.sv */
// Concurrent checks on the ports of the sleep, wake, battery check and routing core.
// Assumes it is bound to rswl_core and connected by port name.
`timescale 1ns/100ps
`default_nettype none
module rswl_monitor
	import rswl_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              arst_n,
	input wire rswl_cfg_t         cfg,
	input wire logic              cmd_valid,
	input wire rswl_cmd_t         cmd,
	input wire logic              lpo_tick,
	input wire logic              battery_meas_done,
	input wire logic [7:0]        battery_code,
	input wire logic              fifo_rd_ready,
	input wire logic              fifo_rd_valid,
	input wire logic [BYTE_W-1:0] fifo_rd_data,
	input wire logic              battery_meas_req,
	input wire logic              synth_tune_req,
	input wire logic              wake_pulse,
	input wire logic [GPIO_N-1:0] gpio_out,
	input wire rswl_status_t      status
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// Tuning lasts thousands of cycles, so its length is counted rather than repeated.
	int tune_cnt;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			tune_cnt <= 0;
		else
			tune_cnt <= (status.state == ST_TUNE) ? tune_cnt + 1 : 0;
	end
	sequence s_go;
		cmd_valid && cmd inside {CMD_SYNTH, CMD_RX}
			&& status.state inside {ST_SLEEP, ST_STANDBY};
	endsequence
	sequence s_leave;
		status.state == ST_TUNE ##1 status.state != ST_TUNE;
	endsequence
	property p_tune_go;
		s_go |=> status.state == ST_TUNE && synth_tune_req;
	endproperty
	a_tune_go: assert property (p_tune_go) else $error("tuning not entered");
	property p_tune_len;
		s_leave |-> tune_cnt >= TUNE_CYCLES;
	endproperty
	a_tune_len: assert property (p_tune_len) else $error("tuning too short");
	property p_pair;
		battery_meas_req == synth_tune_req;
	endproperty
	a_pair: assert property (p_pair) else $error("measure not with tune");
	property p_one_meas;
		battery_meas_req == (status.state == ST_TUNE && $past(status.state) != ST_TUNE);
	endproperty
	a_one_meas: assert property (p_one_meas) else $error("measure count wrong");
	property p_result;
		battery_meas_done |=> status.battery_level_result == $past(battery_code);
	endproperty
	a_result: assert property (p_result) else $error("battery result not held");
	property p_wake;
		wake_pulse |-> $past(lpo_tick) && $past(cfg.sleep_timer_en)
			&& $past(status.state) == ST_SLEEP ##1 !wake_pulse;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without expiry");
	property p_gpio;
		gpio_out != 3'h0 |-> $onehot(gpio_out) && $past(status.state) == ST_RX
			&& !$past(cfg.packet_mode) && $past(cfg.gpio_sel) != GPIO_SEL_NONE;
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin driven out of mode");
	property p_fifo_hold;
		fifo_rd_valid && !fifo_rd_ready |=> fifo_rd_valid && $stable(fifo_rd_data);
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("head byte lost");
	property p_trim;
		$changed(status.lpo_trim) |-> $past(lpo_tick) || $past(lpo_tick, 2);
	endproperty
	a_trim: assert property (p_trim) else $error("trim moved off tick");
endmodule
`default_nettype wire

/* File: dv/rswl_partner.sv */
// Model of the far side: the supply measurement answer and the host reading the FIFO.
// Assumes requests arrive as one-cycle pulses on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module rswl_partner (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       meas_req,
	input  wire logic [7:0] code_in,
	input  wire logic       slow,
	input  wire logic       stall,
	output logic            meas_done,
	output logic      [7:0] code,
	output logic            rd_ready
);
	int wait_cnt;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wait_cnt <= 0;
			meas_done <= 1'b0;
		end else begin
			meas_done <= (wait_cnt == 1);
			if (meas_req)
				wait_cnt <= slow ? 4000 : 3;
			else if (wait_cnt != 0)
				wait_cnt <= wait_cnt - 1;
		end
	end
	// The code is only valid beside the done pulse, so it is inverted elsewhere.
	assign code = meas_done ? code_in : ~code_in;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			rd_ready <= 1'b0;
		else
			rd_ready <= !stall && !rd_ready;
	end
endmodule
`default_nettype wire

/* File: dv/rswl_core_tb_top.sv */
// Self-checking bench for the sleep, wake, battery check and routing core.
// Assumes the partner answers measurements and pops the FIFO.
`timescale 1ns/100ps
`default_nettype none
module rswl_core_tb_top
	import rswl_pkg::*;
;
	logic         clk_sys = 1'b0;
	logic         lpo_tick = 1'b0;
	logic         arst_n, cmd_valid, bit_strobe, overflow_clear, stall, slow;
	logic         demod_i, demod_q, meas_done, meas_req, rd_valid, rd_ready;
	logic [7:0]   code, code_in, rssi, rd_data;
	logic [2:0]   gpio;
	rswl_cfg_t    cfg;
	rswl_cmd_t    cmd;
	rswl_status_t st;
	int           n_mismatch = 0, n_checks = 0, seed = 8, n_req = 0, lpo_per, tcnt = 0;
	logic         was_tune = 1'b0;
	logic         wake, tune_req;
	int           n_wake = 0, n_tune = 0;
	rswl_cmd_t    cl[4] = '{CMD_SYNTH, CMD_RX, CMD_STANDBY, CMD_RX};
	rswl_state_t  sl[4] = '{ST_SYNTH, ST_RX, ST_STANDBY, ST_RX};
	logic         tl[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic [7:0]   bq[$], fq[$];
	always #20 clk_sys = ~clk_sys;
	rswl_core #(.CAL_PERIOD(4)) rswl_core_inst (.clk_sys, .arst_n, .cfg, .cmd_valid, .cmd,
		.lpo_tick, .battery_meas_done(meas_done), .battery_code(code),
		.signal_strength_converter(rssi), .demod_i, .demod_q, .bit_strobe, .overflow_clear,
		.fifo_rd_ready(rd_ready), .fifo_rd_valid(rd_valid), .fifo_rd_data(rd_data),
		.battery_meas_req(meas_req), .synth_tune_req(tune_req), .wake_pulse(wake), .gpio_out(gpio),
		.status(st));
	rswl_partner rswl_partner_inst (.clk_sys, .arst_n, .meas_req, .code_in, .slow, .stall,
		.meas_done, .code, .rd_ready);
	task automatic complete_run();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic send(rswl_cmd_t c);
		cmd = c;
		cmd_valid = 1'b1;
		cyc(1);
		cmd_valid = 1'b0;
		cyc(1);
	endtask
	task automatic wait_st(rswl_state_t s);
		int i;
		for (i = 0; i < 5000 && st.state !== s; i++)
			cyc(1);
		if (i == 5000) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic do_reset(int per);
		arst_n = 1'b0;
		lpo_per = per;
		cyc(10);
		arst_n = 1'b1;
		chk8("state", {3'h0, ST_SLEEP}, {3'h0, st.state});
		chk8("trim", TRIM_RESET, st.lpo_trim);
		chk8("battery", 8'h00, st.battery_level_result);
		cfg = '0;
		cfg.ook_mode = 1'b1;
		cfg.ook_threshold = 8'h80;
		cfg.gpio_sel = GPIO_SEL_NONE;
		cyc(per * 7 / 2);
	endtask
	task automatic put_bit(logic b);
		rssi = b ? 8'hff : 8'h00;
		cyc(3);
		bit_strobe = 1'b1;
		cyc(1);
		bit_strobe = 1'b0;
	endtask
	always @(negedge clk_sys) begin
		tcnt <= (!arst_n || tcnt >= lpo_per - 1) ? 0 : tcnt + 1;
		lpo_tick <= arst_n && (tcnt == lpo_per - 1);
	end
	// -----------------------------------------------------------------
	// Result watcher
	// -----------------------------------------------------------------
	always @(negedge clk_sys) begin
		if (meas_req)
			n_req++;
		if (wake)
			n_wake++;
		if (tune_req)
			n_tune++;
		if (rd_valid && rd_ready)
			chk8("fifo byte", fq.pop_front(), rd_data);
		if (was_tune && st.state !== ST_TUNE)
			chk8("battery", bq.pop_front(), st.battery_level_result);
		was_tune = (st.state === ST_TUNE);
	end
	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		logic [1:0]  ph;
		logic [7:0]  v;
		int          r0;
		{cmd_valid, bit_strobe, overflow_clear, stall, slow, demod_i, demod_q} = 7'h0;
		{rssi, code_in, ph} = 18'h0;
		cmd = CMD_SLEEP;
		cfg = '0;
		do_reset(700);
		chk8("trim", 8'h7e, st.lpo_trim);
		do_reset(781);
		chk8("cal done", 8'h01, {7'h0, st.lpo_cal_done});
		chk8("trim", TRIM_RESET, st.lpo_trim);
		for (int j = 0; j < 4; j++) begin
			code_in = 8'($random(seed));
			slow = (j == 3);
			r0 = n_req;
			if (tl[j])
				bq.push_back(code_in);
			send(cl[j]);
			if (tl[j])
				send(CMD_SLEEP);
			wait_st(sl[j]);
			chk8("tunes", {7'h0, tl[j]}, 8'(n_req - r0));
		end
		slow = 1'b0;
		for (int k = 0; k < 8; k++) begin
			cfg.gpio_sel = k[1:0];
			rssi = k[2] ? 8'($random(seed)) : 8'hff;
			cyc(4);
			chk8("rssi", rssi, st.rssi_code);
			chk8("pin", (k[1:0] != 2'h3 && rssi > 8'h80) ? 8'(1 << k[1:0]) : 8'h00,
				{5'h0, gpio});
		end
		cfg.ook_mode = 1'b0;
		cfg.gpio_sel = 2'h0;
		for (int s = 0; s < 8; s++) begin
			ph = (s < 4) ? ph + 2'h1 : ph - 2'h1;
			demod_i = ph[1];
			demod_q = ph[1] ^ ph[0];
			cyc(3);
			chk8("fsk", {7'h0, s < 4}, {5'h0, gpio});
		end
		cfg.ook_mode = 1'b1;
		cfg.packet_mode = 1'b1;
		stall = 1'b1;
		cyc(2);
		for (int b = 0; b < 6; b++) begin
			v = 8'($random(seed));
			if (b < 5)
				fq.push_back(v);
			for (int i = 7; i >= 0; i--)
				put_bit(v[i]);
		end
		cyc(2);
		chk8("overflow", 8'h01, {7'h0, st.fifo_overflow});
		overflow_clear = 1'b1;
		cyc(1);
		overflow_clear = 1'b0;
		stall = 1'b0;
		cyc(40);
		chk8("overflow", 8'h00, {7'h0, st.fifo_overflow});
		chk8("left", 8'h00, 8'(fq.size()));
		cfg.sleep_timer_en = 1'b1;
		cfg.sleep_ticks = 31'h2;
		send(CMD_SLEEP);
		wait_st(ST_STANDBY);
		cfg.duty_cycle_en = 1'b1;
		cfg.sleep_ticks = 31'h0;
		bq.push_back(code_in);
		send(CMD_SLEEP);
		wait_st(ST_TUNE);
		cyc(3800);
		chk8("pending", 8'h00, 8'(bq.size()));
		chk8("wakes", 8'h02, 8'(n_wake));
		chk8("tune requests", 8'h03, 8'(n_tune));
		complete_run();
	end
endmodule
bind rswl_core rswl_monitor rswl_monitor_inst (.clk_sys, .arst_n, .cfg, .cmd_valid, .cmd,
	.lpo_tick, .battery_meas_done, .battery_code, .fifo_rd_ready, .fifo_rd_valid,
	.fifo_rd_data, .battery_meas_req, .synth_tune_req, .wake_pulse, .gpio_out, .status);
`default_nettype wire
